/* File: src/timer_ccr_consts.svh */
`ifndef TIMER_CCR_CONSTS_SVH
`define TIMER_CCR_CONSTS_SVH
// ==========================================
// register offsets (byte addresses)
`define OFF_CONTROL_ONE 8'h00
`define OFF_CHANNEL2_VALUE 8'h38
`define OFF_CHANNEL3_VALUE 8'h3C
`define OFF_CHANNEL4_VALUE 8'h40
`define OFF_BURST_CONTROL 8'h48
`define OFF_BURST_DATA_PORT 8'h4C
`define OFF_CHANNEL_MODE 8'h50
`define OFF_UPDATE_CTRL 8'h54
`define OFF_BURST_STATUS 8'h58
// ==========================================
// field positions
`define BLEN_MSB 12
`define BLEN_LSB 8
`define BBASE_MSB 4
`define BBASE_LSB 0
`define BURST_CTRL_MASK 16'h1F1F
`define BURST_MAX_FIELD 5'h11
// channel mode register: bit k-2 input-not-output, bit 4+k-2 preload enable
`define MODE_INPUT_LSB 0
`define MODE_PRELOAD_LSB 4
`define UPD_DISABLE_BIT 0
`define UPD_FORCE_BIT 1
`define RESET_VALUE16 16'h0000
`endif

/* File: src/timer_ccr_pkg.sv */
package timer_ccr_pkg;
  typedef logic [15:0] half_t;
  typedef logic [7:0] addr_t;
  typedef enum logic [1:0] {
    BURST_IDLE = 2'b00,
    BURST_RUN = 2'b01
  } burst_state_e;
endpackage

/* File: src/ccr_channel.sv */
`timescale 1ns/10ps
`include "timer_ccr_consts.svh"
module ccr_channel
  import timer_ccr_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // configuration
  input wire logic is_input,
  input wire logic preload_en,
  // events
  input wire logic wr_en,
  input wire timer_ccr_pkg::half_t wr_data,
  input wire logic update_event,
  input wire logic capture_event,
  input wire timer_ccr_pkg::half_t counter,
  // results
  output timer_ccr_pkg::half_t value_out,
  output logic compare_out
);
  half_t value_reg;
  half_t active_reg;
  logic compare_reg;

  // ==========================================
  // value register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      value_reg <= `RESET_VALUE16;
    end else if (is_input && capture_event) begin
      value_reg <= counter;
    end else if (wr_en) begin
      value_reg <= wr_data;
    end
  end

  // ==========================================
  // active compare register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      active_reg <= `RESET_VALUE16;
    end else if (!is_input && wr_en && !preload_en) begin
      active_reg <= wr_data;
    end else if (!is_input && preload_en && update_event) begin
      active_reg <= value_reg;
    end
  end

  // ==========================================
  // compare; registered so the top output is a flop
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      compare_reg <= 1'b0;
    end else begin
      compare_reg <= !is_input && (counter == active_reg);
    end
  end

  assign value_out = value_reg;
  assign compare_out = compare_reg;

  chk_direct_load: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (!is_input && wr_en && !preload_en) |=> active_reg == $past(wr_data)) else $error("direct load missed");
  chk_preload_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (!is_input && preload_en && !update_event && !wr_en) |=> $stable(active_reg)) else $error("preload leaked");
  chk_capture_take: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (is_input && capture_event) |=> value_reg == $past(counter)) else $error("capture lost");
endmodule

/* File: src/burst_sequencer.sv */
`timescale 1ns/10ps
`include "timer_ccr_consts.svh"
module burst_sequencer
  import timer_ccr_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // configuration
  input wire logic [4:0] base_offset,
  input wire logic [4:0] length_field,
  // port access
  input wire logic access,
  input wire logic byte_mode,
  // target
  output timer_ccr_pkg::addr_t target_addr,
  output logic low_byte,
  output logic [4:0] index_out
);
  logic [4:0] index_reg;
  logic low_reg;
  logic last;

  // base plus index, word address converted to bytes
  assign target_addr = addr_t'({3'b000, base_offset} + {3'b000, index_reg}) << 2;
  assign last = (index_reg == length_field);
  assign low_byte = low_reg;
  assign index_out = index_reg;

  // ==========================================
  // transfer index
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      index_reg <= 5'h00;
      low_reg <= 1'b0;
    end else if (access) begin
      if (last) begin
        index_reg <= 5'h00;
        low_reg <= 1'b0;
      end else begin
        index_reg <= index_reg + 5'd1;
        // each byte goes to the next register, halves alternating
        low_reg <= byte_mode && !low_reg;
      end
    end
  end

  chk_wrap_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (access && last) |=> index_reg == 5'h00) else $error("index did not wrap");
  chk_index_step: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (access && !last) |=> index_reg == $past(index_reg) + 5'd1) else $error("index step");
endmodule

/* File: src/timer_ccr_dma_burst.sv */
`timescale 1ns/10ps
`include "timer_ccr_consts.svh"
module timer_ccr_dma_burst
  import timer_ccr_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register port
  input wire timer_ccr_pkg::addr_t ADDR,
  input wire timer_ccr_pkg::half_t WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic BYTE_ACCESS,
  output timer_ccr_pkg::half_t RDATA,
  // time base
  input wire timer_ccr_pkg::half_t TIMER_COUNTER,
  input wire logic COUNTER_OVERFLOW,
  input wire logic COUNTER_UNDERFLOW,
  input wire logic [2:0] IN_CAPTURE_EVENT,
  // outputs
  output logic [2:0] OUT_COMPARE_SIGNAL,
  output logic UPDATE_EVENT,
  // redirected burst access to other timer registers
  output logic EXT_WR,
  output timer_ccr_pkg::addr_t EXT_ADDR,
  output timer_ccr_pkg::half_t EXT_WDATA
);
  import timer_ccr_pkg::*;

  localparam int NCH = 3;

  logic [4:0] burst_length_reg;
  logic [4:0] burst_base_offset_reg;
  logic [2:0] in_mode_reg;
  logic [2:0] preload_reg;
  logic update_disable_reg;
  logic force_update;
  logic update_now;
  logic update_reg;
  logic port_access;
  logic port_write;
  logic burst_low;
  logic [4:0] burst_index;
  addr_t burst_addr;
  addr_t eff_addr;
  half_t eff_wdata;
  logic eff_wr;
  logic eff_rd;
  half_t rdata_reg;
  half_t ch_value [NCH];
  logic [NCH-1:0] ch_wr;
  logic [NCH-1:0] ch_cmp;
  logic ext_wr_reg;
  addr_t ext_addr_reg;
  half_t ext_wdata_reg;

  // ==========================================
  // addresses and helpers
  function automatic logic [1:0] chan_of(input addr_t a);
    unique case (a)
      `OFF_CHANNEL2_VALUE: chan_of = 2'd1;
      `OFF_CHANNEL3_VALUE: chan_of = 2'd2;
      `OFF_CHANNEL4_VALUE: chan_of = 2'd3;
      default: chan_of = 2'd0;
    endcase
  endfunction

  // byte access lands on high byte first, low byte second; other half kept
  function automatic half_t merge_byte(input half_t old, input half_t wd, input logic lo, input logic bm);
    if (!bm) begin
      merge_byte = wd;
    end else if (lo) begin
      merge_byte = {old[15:8], wd[7:0]};
    end else begin
      merge_byte = {wd[7:0], old[7:0]};
    end
  endfunction

  // ==========================================
  // burst redirection
  assign port_access = (WR || RD) && (ADDR == `OFF_BURST_DATA_PORT);
  assign port_write = WR && (ADDR == `OFF_BURST_DATA_PORT);

  burst_sequencer u_seq (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .base_offset(burst_base_offset_reg),
    .length_field(burst_length_reg),
    .access(port_access),
    .byte_mode(BYTE_ACCESS),
    .target_addr(burst_addr),
    .low_byte(burst_low),
    .index_out(burst_index)
  );

  // control one sits at offset zero, so base plus index is the address
  assign eff_addr = port_access ? (`OFF_CONTROL_ONE + burst_addr) : ADDR;
  assign eff_wr = WR;
  assign eff_rd = RD;

  always_comb begin
    eff_wdata = WDATA;
    for (int i = 0; i < NCH; i++) begin
      if (port_access && chan_of(eff_addr) == 2'(i + 1)) begin
        eff_wdata = merge_byte(ch_value[i], WDATA, burst_low, BYTE_ACCESS);
      end
    end
  end

  // ==========================================
  // update event generation
  assign update_now = ((COUNTER_OVERFLOW || COUNTER_UNDERFLOW) && !update_disable_reg) || force_update;
  assign force_update = WR && (eff_addr == `OFF_UPDATE_CTRL) && WDATA[`UPD_FORCE_BIT];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      update_reg <= 1'b0;
    end else begin
      update_reg <= update_now;
    end
  end

  // ==========================================
  // configuration registers
  // a new burst setting keeps the running index; reprogram only between bursts
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      burst_length_reg <= 5'h00;
      burst_base_offset_reg <= 5'h00;
    end else if (WR && ADDR == `OFF_BURST_CONTROL) begin
      burst_length_reg <= (WDATA[`BLEN_MSB:`BLEN_LSB] > `BURST_MAX_FIELD) ?
                          `BURST_MAX_FIELD : WDATA[`BLEN_MSB:`BLEN_LSB];
      burst_base_offset_reg <= WDATA[`BBASE_MSB:`BBASE_LSB];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      in_mode_reg <= 3'b000;
      preload_reg <= 3'b000;
      update_disable_reg <= 1'b0;
    end else if (eff_wr && eff_addr == `OFF_CHANNEL_MODE) begin
      in_mode_reg <= eff_wdata[`MODE_INPUT_LSB +: 3];
      preload_reg <= eff_wdata[`MODE_PRELOAD_LSB +: 3];
    end else if (eff_wr && eff_addr == `OFF_UPDATE_CTRL) begin
      update_disable_reg <= eff_wdata[`UPD_DISABLE_BIT];
    end
  end

  // ==========================================
  // channels 2 to 4
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      assign ch_wr[g] = eff_wr && (chan_of(eff_addr) == 2'(g + 1));
      ccr_channel u_ch (
        .SYS_CLK(SYS_CLK),
        .RST_N(RST_N),
        .is_input(in_mode_reg[g]),
        .preload_en(preload_reg[g]),
        .wr_en(ch_wr[g]),
        .wr_data(eff_wdata),
        .update_event(update_now),
        .capture_event(IN_CAPTURE_EVENT[g]),
        .counter(TIMER_COUNTER),
        .value_out(ch_value[g]),
        .compare_out(ch_cmp[g])
      );
    end
  endgenerate

  // ==========================================
  // redirected writes to registers outside this block
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ext_wr_reg <= 1'b0;
      ext_addr_reg <= 8'h00;
      ext_wdata_reg <= `RESET_VALUE16;
    end else begin
      ext_wr_reg <= port_write && chan_of(eff_addr) == 2'd0;
      ext_addr_reg <= eff_addr;
      ext_wdata_reg <= WDATA;
    end
  end

  // ==========================================
  // read data, one cycle later; unmapped reads return zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_reg <= `RESET_VALUE16;
    end else if (eff_rd) begin
      unique case (eff_addr)
        `OFF_CHANNEL2_VALUE: rdata_reg <= ch_value[0];
        `OFF_CHANNEL3_VALUE: rdata_reg <= ch_value[1];
        `OFF_CHANNEL4_VALUE: rdata_reg <= ch_value[2];
        `OFF_BURST_CONTROL: rdata_reg <= {3'b000, burst_length_reg, 3'b000, burst_base_offset_reg};
        `OFF_CHANNEL_MODE: rdata_reg <= {9'h000, preload_reg, 1'b0, in_mode_reg};
        `OFF_UPDATE_CTRL: rdata_reg <= {15'h0000, update_disable_reg};
        `OFF_BURST_STATUS: rdata_reg <= {11'h000, burst_index};
        default: rdata_reg <= `RESET_VALUE16;
      endcase
    end else begin
      rdata_reg <= `RESET_VALUE16;
    end
  end

  assign RDATA = rdata_reg;
  assign OUT_COMPARE_SIGNAL = ch_cmp;
  assign UPDATE_EVENT = update_reg;
  assign EXT_WR = ext_wr_reg;
  assign EXT_ADDR = ext_addr_reg;
  assign EXT_WDATA = ext_wdata_reg;

  // ==========================================
  // checks: update event
  sequence s_overflow_enabled;
    COUNTER_OVERFLOW && !update_disable_reg;
  endsequence

  sequence s_underflow_enabled;
    COUNTER_UNDERFLOW && !update_disable_reg;
  endsequence

  chk_update_fire: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_overflow_enabled |=> UPDATE_EVENT)
    else $error("update missing");

  chk_underflow_fire: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_underflow_enabled |=> UPDATE_EVENT)
    else $error("underflow update missing");

  chk_force_fire: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    force_update |=> UPDATE_EVENT)
    else $error("forced update missing");

  chk_update_block: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (!COUNTER_OVERFLOW && !COUNTER_UNDERFLOW && !force_update) |=> !UPDATE_EVENT)
    else $error("spurious update");

  // ==========================================
  // checks: register reads
  chk_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == `OFF_BURST_CONTROL) |=> (RDATA & ~`BURST_CTRL_MASK) == 16'h0000)
    else $error("reserved set");

  chk_value_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == `OFF_CHANNEL3_VALUE) |=> RDATA == $past(ch_value[1]))
    else $error("channel value read");

  chk_status_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == `OFF_BURST_STATUS) |=> RDATA == {11'h000, $past(burst_index)})
    else $error("status read");

  chk_length_cap: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    burst_length_reg <= `BURST_MAX_FIELD)
    else $error("length beyond 18");

  // ==========================================
  // checks: burst redirection
  sequence s_port_byte_step;
    port_access && BYTE_ACCESS && (burst_index != burst_length_reg);
  endsequence

  chk_burst_redirect: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (port_write && chan_of(eff_addr) == 2'd0) |=> EXT_WR && EXT_ADDR == $past(eff_addr))
    else $error("redirect lost");

  // expected address rebuilt from the fields, not taken from the sequencer
  chk_redirect_addr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    port_access |-> eff_addr == 8'(4 * (int'(burst_base_offset_reg) + int'(burst_index))))
    else $error("redirect address");

  chk_redirect_data: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (port_write && chan_of(eff_addr) == 2'd0) |=> EXT_WDATA == $past(WDATA))
    else $error("redirect data");

  chk_byte_alternate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_port_byte_step |=> burst_low != $past(burst_low))
    else $error("byte half not alternated");

  // input channels must keep their compare signal low
  for (genvar k = 0; k < NCH; k++) begin : gen_chk
    chk_input_silent: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      in_mode_reg[k] |=> !OUT_COMPARE_SIGNAL[k])
      else $error("input channel compared");
  end
endmodule

/* File: verif/bus_master_model.sv */
`timescale 1ns/10ps
module bus_master_model
  import timer_ccr_pkg::*;
(
  // clock
  input wire logic SYS_CLK,
  // register port
  output timer_ccr_pkg::addr_t ADDR,
  output timer_ccr_pkg::half_t WDATA,
  output logic WR,
  output logic RD,
  output logic BYTE_ACCESS,
  input wire timer_ccr_pkg::half_t RDATA
);
  import timer_ccr_pkg::*;
  // ==========================================
  // idle bus
  initial begin
    ADDR = 8'h00;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
    BYTE_ACCESS = 1'b0;
  end
  // ==========================================
  // processor cycles; one idle cycle between strobes keeps each signal single-driven per step
  task automatic write_reg(input addr_t a, input half_t d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic read_reg(input addr_t a, output half_t d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    @(posedge SYS_CLK);
    d = RDATA;
  endtask
  // ==========================================
  // dma transfer: width chosen by the controller, data in low byte when byte wide
  task automatic dma_transfer(input half_t d, input logic byte_wide);
    @(posedge SYS_CLK);
    ADDR <= 8'h4C;
    WDATA <= d;
    BYTE_ACCESS <= byte_wide;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    BYTE_ACCESS <= 1'b0;
  endtask
endmodule

/* File: verif/test_timer_ccr_dma_burst.sv */
`timescale 1ns/10ps
module test_timer_ccr_dma_burst;
  import timer_ccr_pkg::*;
  typedef struct {addr_t a; half_t d; half_t e;} row_s;
  logic sys_clk, rst_n, ovf, unf, ext_wr, upd;
  logic [2:0] cap, cmp;
  addr_t addr, ext_addr, last_ext_addr;
  half_t wdata, rdata, counter, ext_wdata, last_ext_data, rd;
  logic wr, rd_s, byte_acc;
  int failures = 0, tests_run = 0, cycles = 0, upd_count = 0, ext_hits = 0, n0;
  // reserved bits of burst control come back cleared; 0x44 is unmapped
  row_s rows[5] = '{'{8'h38, 16'hA5A5, 16'hA5A5}, '{8'h3C, 16'h1234, 16'h1234},
    '{8'h40, 16'hFFFF, 16'hFFFF}, '{8'h48, 16'hE2F1, 16'h0211}, '{8'h44, 16'hFFFF, 16'h0000}};
  // ==========================================
  // clock, instances, monitors
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  timer_ccr_dma_burst timer_ccr_dma_burst_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd_s), .BYTE_ACCESS(byte_acc), .RDATA(rdata), .TIMER_COUNTER(counter),
    .COUNTER_OVERFLOW(ovf), .COUNTER_UNDERFLOW(unf), .IN_CAPTURE_EVENT(cap), .OUT_COMPARE_SIGNAL(cmp),
    .UPDATE_EVENT(upd), .EXT_WR(ext_wr), .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata));
  bus_master_model bus_master_model_i (.SYS_CLK(sys_clk), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd_s),
    .BYTE_ACCESS(byte_acc), .RDATA(rdata));
  // counting high cycles also catches a pulse that stands too long
  always @(posedge sys_clk) begin
    cycles++;
    if (upd === 1'b1) upd_count++;
    if (ext_wr === 1'b1) begin
      ext_hits++;
      last_ext_addr = ext_addr;
      last_ext_data = ext_wdata;
    end
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end
  // ==========================================
  // helpers
  task automatic check(input half_t seen, input half_t exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic rd_check(input addr_t a, input half_t exp);
    bus_master_model_i.read_reg(a, rd);
    check(rd, exp, "read back");
  endtask
  task automatic pulse(input int which);
    @(posedge sys_clk);
    if (which == 0) ovf <= 1'b1;
    else unf <= 1'b1;
    @(posedge sys_clk);
    ovf <= 1'b0;
    unf <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    counter = 16'h0000;
    ovf = 1'b0;
    unf = 1'b0;
    cap = 3'b000;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) rd_check(rows[i].a, 16'h0000);
    foreach (rows[i]) begin
      bus_master_model_i.write_reg(rows[i].a, rows[i].d);
      rd_check(rows[i].a, rows[i].e);
    end
    $display("test registers done");
    counter <= 16'h0005;
    bus_master_model_i.write_reg(8'h50, 16'h0000);
    bus_master_model_i.write_reg(8'h38, 16'h0005);
    repeat (3) @(posedge sys_clk);
    check(cmp, 3'b001, "direct compare");
    bus_master_model_i.write_reg(8'h50, 16'h0010);
    bus_master_model_i.write_reg(8'h38, 16'h0007);
    counter <= 16'h0007;
    repeat (3) @(posedge sys_clk);
    check(cmp[0], 1'b0, "preload held");
    n0 = upd_count;
    bus_master_model_i.write_reg(8'h54, 16'h0002);
    repeat (3) @(posedge sys_clk);
    check(16'(upd_count - n0), 16'h0001, "forced update");
    check(cmp[0], 1'b1, "preload moved");
    bus_master_model_i.write_reg(8'h54, 16'h0001);
    pulse(0);
    check(16'(upd_count - n0), 16'h0001, "update disabled");
    bus_master_model_i.write_reg(8'h54, 16'h0000);
    pulse(1);
    check(16'(upd_count - n0), 16'h0002, "underflow update");
    pulse(0);
    check(16'(upd_count - n0), 16'h0003, "overflow update");
    $display("test compare done");
    bus_master_model_i.write_reg(8'h50, 16'h0002);
    counter <= 16'h0ABC;
    cap <= 3'b010;
    @(posedge sys_clk);
    cap <= 3'b000;
    counter <= 16'h0DEF;
    rd_check(8'h3C, 16'h0ABC);
    $display("test capture done");
    bus_master_model_i.write_reg(8'h50, 16'h0000);
    bus_master_model_i.write_reg(8'h48, 16'h020E);
    for (int i = 1; i <= 3; i++) begin
      bus_master_model_i.dma_transfer(16'h1111 * i[15:0], 1'b0);
      if (i == 2) rd_check(8'h58, 16'h0002);
    end
    rd_check(8'h58, 16'h0000);
    rd_check(8'h40, 16'h3333);
    bus_master_model_i.write_reg(8'h48, 16'h000E);
    bus_master_model_i.dma_transfer(16'h4444, 1'b0);
    rd_check(8'h38, 16'h4444);
    for (int b = 0; b < 3; b++) begin
      n0 = ext_hits;
      bus_master_model_i.write_reg(8'h48, 16'(b));
      bus_master_model_i.dma_transfer(16'hBEE0 + 16'(b), 1'b0);
      repeat (2) @(posedge sys_clk);
      check(16'(ext_hits - n0), 16'h0001, "redirected write");
      check({8'h00, last_ext_addr}, 16'(b * 4), "redirect address");
      check(last_ext_data, 16'hBEE0 + 16'(b), "redirect data");
    end
    $display("test burst done");
    bus_master_model_i.write_reg(8'h48, 16'h010E);
    bus_master_model_i.dma_transfer(16'h00AB, 1'b1);
    bus_master_model_i.dma_transfer(16'h00CD, 1'b1);
    rd_check(8'h38, 16'hAB44);
    rd_check(8'h3C, 16'h22CD);
    $display("test byte burst done");
    bus_master_model_i.dma_transfer(16'h5555, 1'b0);
    rd_check(8'h58, 16'h0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_check(8'h38, 16'h0000);
    rd_check(8'h58, 16'h0000);
    rd_check(8'h48, 16'h0000);
    check(cmp, 3'b000, "compare after reset");
    $display("test reset done");
    conclude();
  end
endmodule
